// ---- pkg/wwd_pkg.sv ----
// windowed watchdog package: option byte layout, register map, key codes, timing.
// assumes a single 100 MHz apb clock; the low-speed oscillator tick is derived by division.
// Contract
// - window size comes from option byte bits 6 and 5.
// - window code 01 is 50%, 10 is 75%, 11 is 100%; 00 forbidden.
// - clear key written in open window zeroes the counter and counting resumes.
// - clear key written in closed window raises internal reset.
// - first key write after reset ignores the window and clears the counter.
// - with standby run option zero the window is always 100% open.
// - overflow code picks 2^6,7,8,9,11,13,14,16 oscillator periods.
// - closed window starts at restart, lasts overflow times one minus open fraction.
// - with interval option set, interrupt fires at 75% of overflow time.
// - counting continues after the interval interrupt; overflow raises internal reset.
// - writing any value other than the clear key raises internal reset.
// - a single-bit access to the key register raises internal reset.
// - reading the key register returns its reset value, never the written key.
// - with standby run zero, counting halts in standby and restarts from zero.
package wwd_pkg;

  // option byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic       interval_irq_option;  // bit 7
    logic [1:0] window_select;        // bits 6:5, window_select_hi/lo
    logic       count_enable_option;  // bit 4
    logic [2:0] overflow_select;      // bits 3:1, overflow_select_b2..b0
    logic       standby_run_option;   // bit 0
  } wwd_opt_s;

  typedef enum logic [1:0] {WD_LOAD, WD_RUN, WD_OFF, WD_FAULT} wwd_st_e;

  // register byte offsets
  localparam logic [7:0] OFF_KEY   = 8'h00;
  localparam logic [7:0] OFF_OPT   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_MASK  = 8'h0C;
  localparam logic [7:0] OFF_CNT   = 8'h10;
  localparam logic [7:0] OFF_BITOP = 8'h14;

  // key values
  localparam logic [7:0] KEY_CLEAR  = 8'hAC;
  localparam logic [7:0] KEY_RD_ON  = 8'h9A;
  localparam logic [7:0] KEY_RD_OFF = 8'h1A;

  // window_select codes
  localparam logic [1:0] WIN_BAD = 2'h0;
  localparam logic [1:0] WIN_50  = 2'h1;
  localparam logic [1:0] WIN_75  = 2'h2;
  localparam logic [1:0] WIN_100 = 2'h3;

  // status and mask bit positions
  localparam int ST_INTERVAL = 0;
  localparam int ST_CLEARED  = 1;
  localparam int ST_W        = 2;

  // counter and timing
  localparam int CNT_W       = 17;
  localparam int DIV_W       = 16;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int LS_FREQ_HZ  = 17_250;
  localparam int LS_DIV      = CLK_FREQ_HZ / LS_FREQ_HZ;  // longest period rounds down

  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  localparam logic [7:0]  OPT_RST  = 8'h00;
  localparam logic [ST_W-1:0] STAT_RST = 2'h0;

endpackage

// ---- hdl/wwd_core.sv ----
// windowed watchdog core with an apb3 slave for the key, option view, status, mask and count.
// assumes the option byte is stable from reset release and that presetn is driven by the
// system reset that wdt_reset itself requests.
`timescale 1ns/1ps
`default_nettype none

module wwd_core
  import wwd_pkg::*;
#(
  parameter int DIV_CYCLES = LS_DIV  // pclk cycles per oscillator period
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb3 slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // option byte and power mode
  input  wire logic [7:0]  option_byte,
  input  wire logic        standby,
  // results
  output logic             wdt_reset,
  output logic             interval_interrupt,
  output logic             irq
);

  // exponent of the overflow time per overflow_select code
  function automatic logic [4:0] ovf_exp(input logic [2:0] code);
    unique case (code)
      3'h0: ovf_exp = 5'd6;
      3'h1: ovf_exp = 5'd7;
      3'h2: ovf_exp = 5'd8;
      3'h3: ovf_exp = 5'd9;
      3'h4: ovf_exp = 5'd11;
      3'h5: ovf_exp = 5'd13;
      3'h6: ovf_exp = 5'd14;
      3'h7: ovf_exp = 5'd16;
    endcase
  endfunction

  wwd_opt_s          opt;
  wwd_st_e           st;
  logic [CNT_W-1:0]  count;
  logic [DIV_W-1:0]  div_cnt;
  logic              first_done;
  logic              stby_q;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;

  // derived boundaries
  logic [4:0]        e;
  logic [CNT_W-1:0]  ovf_last;
  logic [CNT_W-1:0]  half;
  logic [CNT_W-1:0]  quarter;
  logic [CNT_W-1:0]  three_q;
  logic [CNT_W-1:0]  open_thr;
  logic              window_open;

  assign e        = ovf_exp(opt.overflow_select);
  assign ovf_last = 17'h1_FFFF >> (5'd17 - e);
  assign half     = 17'h1_0000 >> (5'd17 - e);
  assign quarter  = 17'h1_0000 >> (5'd18 - e);
  assign three_q  = half + quarter;

  // open threshold: closed part is overflow times one minus open fraction
  always_comb begin
    open_thr = '0;
    if (opt.standby_run_option) begin  // forced 100% when zero
      unique case (opt.window_select)
        WIN_50:  open_thr = half;
        WIN_75:  open_thr = quarter;
        default: open_thr = '0;  // 100%, and the forbidden code behaves as 100%
      endcase
    end
  end
  assign window_open = (count >= open_thr);  // one comparator against the selected threshold

  // bus events, all taken at the access edge
  logic wr_acc;
  logic rd_acc;
  logic wr_key;
  logic key_good;
  assign wr_acc   = psel & penable & pready & pwrite;
  assign rd_acc   = psel & penable & pready & ~pwrite;
  assign wr_key   = wr_acc & (paddr == OFF_KEY);
  assign key_good = (pwdata[7:0] == KEY_CLEAR);

  // counting conditions and faults
  logic tick;
  logic counting;
  logic stby_exit;
  logic clear_ok;
  logic bad_key;
  logic bit_hit;
  logic closed_hit;
  logic ovf_hit;
  logic iv_hit;
  logic fault_now;
  assign tick       = (div_cnt == DIV_W'(DIV_CYCLES - 1));
  assign counting   = (st == WD_RUN) & ~(standby & ~opt.standby_run_option);
  assign stby_exit  = (st == WD_RUN) & stby_q & ~standby & ~opt.standby_run_option;
  assign clear_ok   = wr_key & key_good & (~first_done | window_open);
  assign bad_key    = wr_key & ~key_good;
  assign bit_hit    = wr_acc & (paddr == OFF_BITOP);
  assign closed_hit = wr_key & key_good & first_done & ~window_open
                      & (st == WD_RUN);
  // a clear in the last period wins over the overflow
  assign ovf_hit    = counting & tick & (count == ovf_last) & ~clear_ok;
  // fire on the tick that brings the count to three quarters, not one period later
  assign iv_hit     = counting & tick & (count == three_q - 1'b1)
                      & opt.interval_irq_option;
  assign fault_now  = (st != WD_LOAD) & (bad_key | bit_hit | closed_hit | ovf_hit);

  // option capture one cycle after release, then the run or off state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt       <= wwd_opt_s'(OPT_RST);
      st        <= WD_LOAD;
      wdt_reset <= 1'b0;
    end else begin
      unique case (st)
        WD_LOAD: begin
          opt <= wwd_opt_s'(option_byte);  // strap caught after release
          st  <= option_byte[4] ? WD_RUN : WD_OFF;
        end
        WD_RUN, WD_OFF: begin
          if (fault_now) begin
            st        <= WD_FAULT;
            wdt_reset <= 1'b1;  // held until the system reset arrives
          end
        end
        WD_FAULT: wdt_reset <= 1'b1;
      endcase
    end
  end

  // oscillator divider, watchdog counter and first-write flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt    <= '0;
      count      <= '0;
      first_done <= 1'b0;
      stby_q     <= 1'b0;
    end else begin
      stby_q <= standby;
      if (clear_ok && st != WD_LOAD) begin
        div_cnt    <= '0;
        count      <= '0;  // restart counting from zero
        first_done <= 1'b1;
      end else if (stby_exit) begin
        div_cnt <= '0;
        count   <= '0;  // resume from zero after standby
      end else if (counting) begin
        div_cnt <= tick ? '0 : div_cnt + 1'b1;
        if (tick) begin
          count <= count + 1'b1;  // keeps running past the interval point
        end
      end
    end
  end

  // sticky status, mask and interrupt; a new event beats a clearing write
  logic [ST_W-1:0] evt;
  logic [ST_W-1:0] next_status;
  always_comb begin
    evt              = '0;
    evt[ST_INTERVAL] = iv_hit;
    evt[ST_CLEARED]  = clear_ok & (st == WD_RUN);
    next_status      = status;
    if (wr_acc && paddr == OFF_STAT) begin
      next_status = status & ~pwdata[ST_W-1:0];
    end
    next_status = next_status | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status             <= STAT_RST;
      mask               <= STAT_RST;
      irq                <= 1'b0;
      interval_interrupt <= 1'b0;
    end else begin
      status             <= next_status;
      interval_interrupt <= iv_hit;  // one-cycle pulse
      if (wr_acc && paddr == OFF_MASK) begin
        mask <= pwdata[ST_W-1:0];
        irq  <= |(next_status & pwdata[ST_W-1:0]);
      end else begin
        irq <= |(next_status & mask);
      end
    end
  end

  // apb answer: no wait state, read data prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RD_ZERO;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata  <= RD_ZERO;
        unique case (paddr)
          OFF_KEY:   prdata[7:0] <= opt.count_enable_option ? KEY_RD_ON : KEY_RD_OFF;
          OFF_OPT:   prdata[7:0] <= opt;
          OFF_STAT:  prdata[ST_W-1:0] <= status;  // interval flag lets software time clears
          OFF_MASK:  prdata[ST_W-1:0] <= mask;
          OFF_CNT:   prdata[CNT_W:0] <= {window_open, count};
          OFF_BITOP: prdata <= RD_ZERO;
          default:   pslverr <= 1'b1;
        endcase
      end else if (pready) begin
        pslverr <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_good_key;
    wr_key && key_good && st != WD_LOAD;
  endsequence

  a_open_clear: assert property (s_good_key ##0 (first_done && window_open) |=> count == '0)
    else $error("clear in open window did not zero the count");
  a_closed_write: assert property (s_good_key ##0 (first_done && !window_open && st == WD_RUN)
                                   |=> wdt_reset ##1 wdt_reset)
    else $error("clear in closed window did not reset");
  a_first_write: assert property (s_good_key ##0 (!first_done && st == WD_RUN && !ovf_hit)
                                  |=> !wdt_reset && count == '0 && first_done)
    else $error("first clear was not accepted");
  a_window_full: assert property (!opt.standby_run_option |-> window_open)
    else $error("window closed with standby run option zero");
  a_window_half: assert property (opt.standby_run_option && opt.window_select == WIN_50
                                  && count == half - 1'b1 |-> !window_open)
    else $error("50 percent window opened early");
  a_interval_on: assert property (iv_hit |=> interval_interrupt && status[ST_INTERVAL])
    else $error("interval interrupt missing at three quarters");
  a_interval_off: assert property (!opt.interval_irq_option |-> !interval_interrupt)
    else $error("interval interrupt while disabled");
  a_overflow: assert property (counting && tick && count == ovf_last && !clear_ok
                               |=> wdt_reset)
    else $error("overflow did not raise reset");
  a_bad_key: assert property (bad_key && st != WD_LOAD |=> wdt_reset)
    else $error("wrong key did not raise reset");
  a_bit_access: assert property (bit_hit && st != WD_LOAD |=> wdt_reset)
    else $error("bit access did not raise reset");
  a_key_read: assert property (rd_acc && paddr == OFF_KEY
                               |-> prdata[7:0] == (opt.count_enable_option ? KEY_RD_ON : KEY_RD_OFF))
    else $error("key register read back the wrong value");
  a_standby_hold: assert property (st == WD_RUN && standby && !opt.standby_run_option && !clear_ok
                                   |=> $stable(count) || count == '0)
    else $error("counter moved in standby");
  a_standby_exit: assert property (stby_exit && !fault_now |=> count == '0)
    else $error("counter not cleared after standby");

  // option capture and counter bounds
  a_opt_capture: assert property (st == WD_LOAD |=> opt == wwd_opt_s'($past(option_byte)))
    else $error("option byte not captured after release");
  a_load_leave: assert property (st == WD_LOAD |=> st != WD_LOAD)
    else $error("watchdog stayed in the load state");
  a_count_bound: assert property (st == WD_RUN |-> count <= ovf_last)
    else $error("count ran past the overflow point");

  // the 75% window opens at one quarter of the overflow time
  a_win75_shut: assert property (opt.standby_run_option && opt.window_select == WIN_75
                                 && count == quarter - 1'b1 |-> !window_open)
    else $error("75 percent window opened early");
  a_win75_open: assert property (opt.standby_run_option && opt.window_select == WIN_75
                                 && count == quarter |-> window_open)
    else $error("75 percent window did not open");

  // interval point: the tick that makes the count reach three quarters
  sequence s_iv_tick;
    counting && tick && count == three_q - 1'b1;
  endsequence
  a_interval_time: assert property (s_iv_tick ##0 opt.interval_irq_option |=> interval_interrupt)
    else $error("interval interrupt not at three quarters");

  // overflow step: the last tick without a clear, then a held reset request
  sequence s_ovf_tick;
    counting && tick && count == ovf_last && !clear_ok;
  endsequence
  a_overflow_held: assert property (s_ovf_tick |=> wdt_reset ##1 (wdt_reset && st == WD_FAULT))
    else $error("overflow reset request not held");

  // status events and the interrupt level
  a_clear_status: assert property (clear_ok && st == WD_RUN |=> status[ST_CLEARED])
    else $error("accepted clear not flagged");
  a_irq_level: assert property (irq == |(status & mask))
    else $error("interrupt level disagrees with status and mask");

endmodule

`default_nettype wire

// ---- verif/windowed_watchdog_timer_tb.sv ----
// self-checking bench for the windowed watchdog core: apb tasks and call sequences.
// assumes a 100 MHz pclk. DIV_CYCLES is 4 here, so one oscillator tick is four pclk cycles.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_tb
  import wwd_pkg::*;
;
  localparam logic [31:0] KW = {24'h00_0000, KEY_CLEAR};

  logic        pclk, presetn, psel, penable, pwrite, standby;
  logic [7:0]  paddr, option_byte, ob;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, wdt_reset, interval_interrupt, irq, er;
  int          n_fail, compares, ic;

  wwd_core #(.DIV_CYCLES(4)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_byte(option_byte), .standby(standby), .wdt_reset(wdt_reset),
    .interval_interrupt(interval_interrupt), .irq(irq)
  );

  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // count interval pulses since the last reset
  always @(posedge pclk) begin
    if (presetn !== 1'b1) ic <= 0;
    else if (interval_interrupt === 1'b1) ic <= ic + 1;
  end

  function automatic logic [7:0] mk(input logic i, input logic [1:0] w, input logic e,
                                    input logic [2:0] o, input logic s);
    mk = wwd_opt_s'{i, w, e, o, s};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; the request stands until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) chk(32'h0000_0bad, 32'h0000_0000);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // reset for five cycles with a new option byte; the task returns three edges after release
  task automatic restart(input logic [7:0] o);
    @(posedge pclk);
    presetn <= 1'b0; option_byte <= o; standby <= 1'b0; ob = o;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic wdt_is(input logic exp);
    repeat (2) @(posedge pclk);
    chk(32'(wdt_reset), 32'(exp));
  endtask

  // hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  initial begin : main
    logic [1:0] t_win [6];
    logic       t_sb  [6];
    logic       t_rst [6];
    int         t_gap [6];
    t_win = '{WIN_50, WIN_50, WIN_75, WIN_75, WIN_100, WIN_50};
    t_sb  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    t_rst = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    t_gap = '{40, 150, 40, 90, 8, 8};  // the 90-cycle 75% clear lands after the prohibited slot
    n_fail = 0; compares = 0; presetn = 1'b0; option_byte = 8'h00; standby = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    // reset view, map, first clear, window clear, status and interval, then overflow
    restart(mk(1'b1, WIN_50, 1'b1, 3'h0, 1'b1));
    rdc(OFF_KEY, {24'h00_0000, KEY_RD_ON});
    rdc(OFF_OPT, {24'h00_0000, ob});
    rdc(8'h18, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    wr(OFF_KEY, KW);
    wdt_is(1'b0);
    wr(OFF_MASK, 32'h0000_0003);
    repeat (150) @(posedge pclk);
    wr(OFF_KEY, KW);
    apb(OFF_CNT, 1'b0, 32'h0000_0000);
    chk(32'(rd[16:0] < 17'h0_0004), 32'h0000_0001);
    chk(32'(rd[17]), 32'h0000_0000);
    rdc(OFF_STAT, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wr(OFF_STAT, 32'h0000_0003);
    rdc(OFF_STAT, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // the pulse must come within one tick period of 48 ticks after the clear
    repeat (176) @(posedge pclk);
    chk(32'(ic), 32'h0000_0000);
    repeat (8) @(posedge pclk);
    chk(32'(ic), 32'h0000_0001);
    repeat (16) @(posedge pclk);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(wdt_reset), 32'h0000_0000);
    repeat (60) @(posedge pclk);
    chk(32'(wdt_reset), 32'h0000_0001);
    // second clear after a gap, against the 50%, 75% and 100% window codes and the standby override
    for (int i = 0; i < 6; i++) begin
      restart(mk(1'b0, t_win[i], 1'b1, 3'h0, t_sb[i]));
      wr(OFF_KEY, KW);
      repeat (t_gap[i]) @(posedge pclk);
      wr(OFF_KEY, KW);
      wdt_is(t_rst[i]);
    end
    // wrong key and single-bit alias both fault at once
    for (int i = 0; i < 2; i++) begin
      restart(mk(1'b0, WIN_100, 1'b1, 3'h0, 1'b1));
      wr(i ? OFF_BITOP : OFF_KEY, i ? 32'h0000_0001 : 32'h0000_0055);
      wdt_is(1'b1);
    end
    // overflow time for the two shortest codes, interval option off
    for (int o = 0; o < 2; o++) begin
      restart(mk(1'b0, WIN_100, 1'b1, 3'(o), 1'b1));
      repeat ((64 << o) * 4 - 30) @(posedge pclk);
      chk(32'(wdt_reset), 32'h0000_0000);
      chk(32'(ic), 32'h0000_0000);
      repeat (60) @(posedge pclk);
      chk(32'(wdt_reset), 32'h0000_0001);
    end
    // standby pauses the count; leaving it restarts from zero
    restart(mk(1'b0, WIN_100, 1'b1, 3'h0, 1'b0));
    repeat (100) @(posedge pclk);
    standby <= 1'b1;
    repeat (400) @(posedge pclk);
    chk(32'(wdt_reset), 32'h0000_0000);
    standby <= 1'b0;  // bench cpu runs at once on wake-up, no settling eats the overflow
    apb(OFF_CNT, 1'b0, 32'h0000_0000);
    chk(32'(rd[16:0] < 17'h0_0004), 32'h0000_0001);
    // counting disabled: other reset view of the key, no overflow
    restart(mk(1'b0, WIN_100, 1'b0, 3'h0, 1'b1));
    rdc(OFF_KEY, {24'h00_0000, KEY_RD_OFF});
    repeat (300) @(posedge pclk);
    chk(32'(wdt_reset), 32'h0000_0000);
    wrap_up();
  end
endmodule

`default_nettype wire
